// *** rtl/dapp_top.sv ***
/*
  DDR2 address mapper, open-page tracker and request queues for 16-bit memory.
  Assumes a memory PHY on the same clock that takes one command per handshake
  and returns read data only for reads it was given, in order.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dapp_defines.svh"

// ---------------------------------------------------------------
// queue used for commands, write data and read data
// ---------------------------------------------------------------
module dapp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(D+1)-1:0] count_o
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = cnt_q != CW'(D);
  assign out_valid_o = cnt_q != '0;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_q[rd_q];
  assign count_o = cnt_q;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule

// ---------------------------------------------------------------
// top level
// ---------------------------------------------------------------
module dapp_top
  import dapp_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic DUAL_CHIP_SELECT_EN_I,
  input wire logic [1:0] INTERNAL_BANK_COUNT_I,
  input wire logic [1:0] PAGE_SIZE_CODE_I,
  input wire logic CMD_VALID_I,
  output logic CMD_READY_O,
  input wire dapp_req_type CMD_REQ_I,
  input wire logic WDATA_VALID_I,
  output logic WDATA_READY_O,
  input wire logic [`DAPP_DATA_BITS-1:0] WDATA_I,
  output logic RDATA_VALID_O,
  input wire logic RDATA_READY_I,
  output logic [`DAPP_DATA_BITS-1:0] RDATA_O,
  output logic MEM_CMD_VALID_O,
  input wire logic MEM_CMD_READY_I,
  output dapp_mem_cmd_type MEM_CMD_O,
  output logic [2:0] MEM_BANK_O,
  output logic [`DAPP_ROW_BITS-1:0] MEM_ADDR_O,
  output logic [1:0] MEM_CS_N_O,
  output logic [1:0] MEM_BYTE_MASK_O,
  output logic [`DAPP_DATA_BITS-1:0] MEM_WDATA_O,
  input wire logic MEM_RDATA_VALID_I,
  input wire logic [`DAPP_DATA_BITS-1:0] MEM_RDATA_I,
  output logic [4:0] OPEN_BANK_COUNT_O
);
  localparam int RW = `DAPP_ROW_BITS;
  localparam int DW = `DAPP_DATA_BITS;
  localparam int QW = $bits(dapp_req_type);

  dapp_state_type state_q;
  dapp_req_type head;
  logic head_valid;
  logic head_pop;
  logic [DW-1:0] wd_head;
  logic wd_valid;
  logic wd_pop;
  logic rd_push;
  logic [DW-1:0] rd_push_data;
  logic rd_in_ready;
  logic [4:0] rd_cnt;
  logic [4:0] rd_out_q;
  logic [15:0] open_q;
  logic [RW-1:0] row_q [`DAPP_BANK_SLOTS];
  logic [DW-1:0] scratch_q;
  logic reg_rd;
  logic reg_wr;
  // decoded fields of the request at the queue head
  logic [30:0] s_col;
  logic [30:0] s_bank;
  logic [30:0] s_cs;
  logic [10:0] col_d;
  logic [2:0] bank_d;
  logic cs_d;
  logic [RW-1:0] row_d;
  // latched request being worked on
  logic [10:0] col_q;
  logic [2:0] bank_q;
  logic cs_q;
  logic [RW-1:0] row_q_req;
  logic wr_q;
  logic byte_q;
  logic lsb_q;
  logic [3:0] slot;
  logic can_emit;
  logic rd_room;
  logic need_pre;
  logic need_act;
  logic go_col;

  // ---------------------------------------------------------------
  // queues, each on its own path
  // ---------------------------------------------------------------
  dapp_fifo #(.W(QW), .D(`DAPP_CMD_DEPTH)) u_cmd_q (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(CMD_VALID_I),
    .in_ready_o(CMD_READY_O),
    .in_data_i(CMD_REQ_I),
    .out_valid_o(head_valid),
    .out_ready_i(head_pop),
    .out_data_o(head),
    .count_o()
  );

  dapp_fifo #(.W(DW), .D(`DAPP_WR_DEPTH)) u_wr_q (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(WDATA_VALID_I),
    .in_ready_o(WDATA_READY_O),
    .in_data_i(WDATA_I),
    .out_valid_o(wd_valid),
    .out_ready_i(wd_pop),
    .out_data_o(wd_head),
    .count_o()
  );

  dapp_fifo #(.W(DW), .D(`DAPP_RD_DEPTH)) u_rd_q (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(rd_push),
    .in_ready_o(rd_in_ready),
    .in_data_i(rd_push_data),
    .out_valid_o(RDATA_VALID_O),
    .out_ready_i(RDATA_READY_I),
    .out_data_o(RDATA_O),
    .count_o(rd_cnt)
  );

  // ---------------------------------------------------------------
  // logical address to column, bank, select and row
  // ---------------------------------------------------------------
  // column sits lowest so a linear walk fills a page, then the next bank,
  // then the other device, before the row moves on
  always_comb begin
    s_col = head.addr[31:1];
    col_d = s_col[10:0] & (11'h7FF >> (2'h3 - PAGE_SIZE_CODE_I));
    s_bank = s_col >> (4'h8 + {2'h0, PAGE_SIZE_CODE_I});
    bank_d = s_bank[2:0] & (3'h7 >> (2'h3 - INTERNAL_BANK_COUNT_I));
    s_cs = s_bank >> INTERNAL_BANK_COUNT_I;
    cs_d = DUAL_CHIP_SELECT_EN_I & s_cs[0];
    row_d = DUAL_CHIP_SELECT_EN_I ? s_cs[RW:1] : s_cs[RW-1:0];
    if (DUAL_CHIP_SELECT_EN_I && INTERNAL_BANK_COUNT_I == 2'h3 &&
        PAGE_SIZE_CODE_I == 2'h3) begin
      row_d = {1'b0, s_cs[RW-1:1]};
    end
  end

  // ---------------------------------------------------------------
  // request sequencing
  // ---------------------------------------------------------------
  assign slot = {cs_q, bank_q};
  assign can_emit = !MEM_CMD_VALID_O || MEM_CMD_READY_I;
  // a read is only sent when its data is sure to find a queue slot
  assign rd_room = ({1'b0, rd_out_q} + {1'b0, rd_cnt}) < 6'(`DAPP_RD_DEPTH);
  assign need_pre = open_q[slot] && row_q[slot] != row_q_req;
  assign need_act = !open_q[slot];
  assign go_col = state_q == ST_RUN && can_emit && !need_pre && !need_act &&
                  (wr_q ? wd_valid : rd_room);
  // register access shares the request port with memory traffic
  assign reg_rd = state_q == ST_IDLE && head_valid && head.reg_sel &&
                  !head.is_write && rd_out_q == 5'h0 && rd_in_ready;
  assign reg_wr = state_q == ST_IDLE && head_valid && head.reg_sel &&
                  head.is_write && wd_valid;
  assign head_pop = reg_rd || reg_wr ||
                    (state_q == ST_IDLE && head_valid && !head.reg_sel);
  assign wd_pop = reg_wr || (go_col && wr_q);
  // no memory read is outstanding when a register read pushes
  assign rd_push = MEM_RDATA_VALID_I || reg_rd;
  assign rd_push_data = MEM_RDATA_VALID_I ? MEM_RDATA_I :
                        (head.addr[`DAPP_REG_SEL_BIT] == `DAPP_REG_STATUS) ?
                        {11'h000, OPEN_BANK_COUNT_O} : scratch_q;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
    end else if (state_q == ST_IDLE) begin
      if (head_valid && !head.reg_sel) begin
        state_q <= ST_RUN;
      end
    end else if (go_col) begin
      state_q <= ST_IDLE;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      col_q <= 11'h000;
      bank_q <= 3'h0;
      cs_q <= 1'b0;
      row_q_req <= '0;
      wr_q <= 1'b0;
      byte_q <= 1'b0;
      lsb_q <= 1'b0;
    end else if (state_q == ST_IDLE && head_valid && !head.reg_sel) begin
      col_q <= col_d;
      bank_q <= bank_d;
      cs_q <= cs_d;
      row_q_req <= row_d;
      wr_q <= head.is_write;
      byte_q <= head.byte_acc;
      lsb_q <= head.addr[0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      scratch_q <= 16'h0000;
    end else if (reg_wr && head.addr[`DAPP_REG_SEL_BIT] == `DAPP_REG_SCRATCH) begin
      scratch_q <= wd_head;
    end
  end

  // ---------------------------------------------------------------
  // open page table
  // ---------------------------------------------------------------
  // rows are closed only on a miss, never at the end of an access
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      open_q <= 16'h0000;
    end else if (state_q == ST_RUN && can_emit) begin
      if (need_pre) begin
        open_q[slot] <= 1'b0;
      end else if (need_act) begin
        open_q[slot] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (state_q == ST_RUN && can_emit && !need_pre && need_act) begin
      row_q[slot] <= row_q_req;
    end
  end

  always_comb begin
    OPEN_BANK_COUNT_O = 5'h00;
    for (int i = 0; i < `DAPP_BANK_SLOTS; i++) begin
      OPEN_BANK_COUNT_O = OPEN_BANK_COUNT_O + {4'h0, open_q[i]};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rd_out_q <= 5'h00;
    end else begin
      rd_out_q <= rd_out_q + {4'h0, go_col && !wr_q} - {4'h0, MEM_RDATA_VALID_I};
    end
  end

  // ---------------------------------------------------------------
  // memory command output register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      MEM_CMD_VALID_O <= 1'b0;
      MEM_CMD_O <= MC_ACT;
      MEM_BANK_O <= 3'h0;
      MEM_ADDR_O <= '0;
      MEM_CS_N_O <= 2'h3;
      MEM_BYTE_MASK_O <= 2'h0;
      MEM_WDATA_O <= 16'h0000;
    end else if (can_emit) begin
      MEM_CMD_VALID_O <= state_q == ST_RUN && (need_pre || need_act || go_col);
      MEM_BANK_O <= bank_q;
      MEM_CS_N_O <= cs_q ? 2'h1 : 2'h2;
      if (need_pre) begin
        MEM_CMD_O <= MC_PRE;
        MEM_ADDR_O <= '0;
      end else if (need_act) begin
        MEM_CMD_O <= MC_ACT;
        MEM_ADDR_O <= row_q_req;
      end else begin
        MEM_CMD_O <= wr_q ? MC_WR : MC_RD;
        MEM_ADDR_O <= {3'h0, col_q};
        // data is passed unshifted in its lane; a byte access masks the unused lane
        MEM_BYTE_MASK_O <= byte_q ? (lsb_q ? 2'h1 : 2'h2) : 2'h0;
        MEM_WDATA_O <= wd_head;
      end
    end
  end
endmodule

`default_nettype wire

// *** rtl/dapp_defines.svh ***
/*
  Constants for the DDR2 address mapper and page policy block: queue depths,
  address field sizes and register-space select codes.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef DAPP_DEFINES_SVH
`define DAPP_DEFINES_SVH

// ---------------------------------------------------------------
// queue depths (entries)
// ---------------------------------------------------------------
`define DAPP_CMD_DEPTH 7
`define DAPP_WR_DEPTH 7
`define DAPP_RD_DEPTH 17

// ---------------------------------------------------------------
// address field sizes
// ---------------------------------------------------------------
`define DAPP_ROW_BITS 14
`define DAPP_BASE_COL_BITS 8
`define DAPP_MAX_COL_BITS 11
`define DAPP_BANK_SLOTS 16
`define DAPP_DATA_BITS 16

// ---------------------------------------------------------------
// register within the reg_sel space picked by address bit 1 on the shared port
// ---------------------------------------------------------------
`define DAPP_REG_SEL_BIT 1
`define DAPP_REG_SCRATCH 1'h0
`define DAPP_REG_STATUS 1'h1

`endif

// *** rtl/dapp_pkg.sv ***
/*
  Types shared by the DDR2 address mapper and page policy block.
  Assumes dapp_defines.svh is on the include path.
*/
`include "dapp_defines.svh"

package dapp_pkg;

  typedef enum logic [1:0] {
    MC_ACT = 2'h0,
    MC_PRE = 2'h1,
    MC_RD = 2'h2,
    MC_WR = 2'h3
  } dapp_mem_cmd_type;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } dapp_state_type;

  typedef struct packed {
    logic [31:0] addr;
    logic is_write;
    logic reg_sel;
    logic byte_acc;
  } dapp_req_type;

endpackage

// *** test/dapp_mem_model.sv ***
/*
  Behavioural DDR2 memory for the mapper bench: keeps the row opened in each
  bank and answers each read two cycles later with a select/bank/row/column pattern.
  Assumes the controller clock and one command per handshake.
*/
`timescale 1ns/1ps
`default_nettype none
module dapp_mem_model
  import dapp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic stall_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire dapp_mem_cmd_type cmd_i,
  input wire logic [2:0] bank_i,
  input wire logic [13:0] addr_i,
  input wire logic [1:0] cs_n_i,
  output logic rdata_valid_o,
  output logic [15:0] rdata_o
);
  logic [13:0] row_q [16];
  logic av_q, rv_q;
  logic [15:0] ad_q, rd_q;
  wire logic acc = cmd_valid_i & cmd_ready_o;
  wire logic [3:0] idx = {cs_n_i[0], bank_i};
  assign cmd_ready_o = !stall_i;
  assign rdata_valid_o = rv_q;
  // idle data lines show the inverse of the last word, never a stale copy
  assign rdata_o = rv_q ? rd_q : ~rd_q;
  always_ff @(posedge clk_i) begin
    if (acc && cmd_i == MC_ACT) row_q[idx] <= addr_i;
  end
  always_ff @(posedge clk_i) begin
    av_q <= rst_n_i & acc & (cmd_i == MC_RD);
    ad_q <= {idx, 1'b0, addr_i[10:0]} ^ {row_q[idx], 2'h0};
    rv_q <= rst_n_i & av_q;
    if (av_q) rd_q <= ad_q;
  end
endmodule
`default_nettype wire

// *** test/dapp_top_assertions.sv ***
/*
  Concurrent checks on the memory command stream, open pages and read return.
  Assumes it is bound into dapp_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module dapp_top_assertions
  import dapp_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic DUAL_CHIP_SELECT_EN_I,
  input wire logic [1:0] INTERNAL_BANK_COUNT_I,
  input wire logic MEM_CMD_VALID_O,
  input wire logic MEM_CMD_READY_I,
  input wire dapp_mem_cmd_type MEM_CMD_O,
  input wire logic [2:0] MEM_BANK_O,
  input wire logic [13:0] MEM_ADDR_O,
  input wire logic [1:0] MEM_CS_N_O,
  input wire logic [1:0] MEM_BYTE_MASK_O,
  input wire logic MEM_RDATA_VALID_I,
  input wire logic RDATA_VALID_O,
  input wire logic [4:0] OPEN_BANK_COUNT_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire logic acc = MEM_CMD_VALID_O & MEM_CMD_READY_I;
  wire logic [3:0] idx = {MEM_CS_N_O[0], MEM_BANK_O};
  dapp_mem_cmd_type last_q;
  logic [3:0] lidx_q;
  // previous accepted command, to check what must follow it
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      last_q <= MC_RD;
      lidx_q <= 4'h0;
    end else if (acc) begin
      last_q <= MEM_CMD_O;
      lidx_q <= idx;
    end
  end
  a_cmd_hold: assert property (MEM_CMD_VALID_O && !MEM_CMD_READY_I |=> MEM_CMD_VALID_O
    && $stable({MEM_CMD_O, MEM_BANK_O, MEM_ADDR_O})) else $error("command changed while stalled");
  a_pre_then_act: assert property (acc && last_q == MC_PRE |-> MEM_CMD_O == MC_ACT
    && idx == lidx_q) else $error("precharge not followed by activate");
  a_act_then_col: assert property (acc && last_q == MC_ACT |-> idx == lidx_q
    && MEM_CMD_O inside {MC_RD, MC_WR}) else $error("activate not followed by access");
  a_open_limit: assert property (OPEN_BANK_COUNT_O <=
    (5'h1 << INTERNAL_BANK_COUNT_I) << DUAL_CHIP_SELECT_EN_I) else $error("too many open");
  // the table drops a row as the precharge is loaded, so it stands on the port then
  a_rows_stay: assert property (OPEN_BANK_COUNT_O < $past(OPEN_BANK_COUNT_O) |->
    MEM_CMD_VALID_O && MEM_CMD_O == MC_PRE) else $error("row closed without precharge");
  a_single_cs: assert property (!DUAL_CHIP_SELECT_EN_I && MEM_CMD_VALID_O |->
    MEM_CS_N_O == 2'h2) else $error("second select used in single mode");
  a_one_cs: assert property (MEM_CMD_VALID_O |-> MEM_CS_N_O inside {2'h1, 2'h2})
    else $error("select not one-hot");
  a_bank_range: assert property (MEM_CMD_VALID_O |->
    MEM_BANK_O < (4'h1 << INTERNAL_BANK_COUNT_I)) else $error("bank out of range");
  a_rd_return: assert property (MEM_RDATA_VALID_I |=> RDATA_VALID_O)
    else $error("returned read not queued");
  a_mask_lanes: assert property (MEM_CMD_VALID_O |-> MEM_BYTE_MASK_O != 2'h3)
    else $error("both lanes masked");
endmodule
bind dapp_top dapp_top_assertions i_chk (.CLK_I, .RST_N_I, .DUAL_CHIP_SELECT_EN_I,
  .INTERNAL_BANK_COUNT_I, .MEM_CMD_VALID_O, .MEM_CMD_READY_I, .MEM_CMD_O, .MEM_BANK_O,
  .MEM_ADDR_O, .MEM_CS_N_O, .MEM_BYTE_MASK_O, .MEM_RDATA_VALID_I, .RDATA_VALID_O,
  .OPEN_BANK_COUNT_O);
`default_nettype wire

// *** test/tb_dapp_top.sv ***
/*
  Self-checking bench for the DDR2 mapper: bank sweeps, row misses, register
  space and random reads over six configurations, queue fill in the first.
  Assumes the memory model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_dapp_top;
  import dapp_pkg::*;
  logic CLK_I = 0, RST_N_I = 0, DUAL_CHIP_SELECT_EN_I = 0, CMD_VALID_I = 0, CMD_READY_O;
  logic [1:0] INTERNAL_BANK_COUNT_I = 0, PAGE_SIZE_CODE_I = 0, MEM_CS_N_O, MEM_BYTE_MASK_O;
  logic WDATA_VALID_I = 0, WDATA_READY_O, RDATA_VALID_O, RDATA_READY_I = 0, MEM_CMD_VALID_O;
  logic MEM_CMD_READY_I, MEM_RDATA_VALID_I, stall = 0, hold = 0;
  logic [15:0] WDATA_I = 0, RDATA_O, MEM_WDATA_O, MEM_RDATA_I, wexp = 0;
  logic [13:0] MEM_ADDR_O;
  logic [2:0] MEM_BANK_O;
  logic [4:0] OPEN_BANK_COUNT_O;
  dapp_req_type CMD_REQ_I = '0;
  dapp_mem_cmd_type MEM_CMD_O;
  int seed = 57, fail_count = 0, checked = 0, cyc = 0, n_act = 0, n_pre = 0;
  logic [15:0] expq [$];
  dapp_top i_dut (.CLK_I, .RST_N_I, .DUAL_CHIP_SELECT_EN_I, .INTERNAL_BANK_COUNT_I,
    .PAGE_SIZE_CODE_I, .CMD_VALID_I, .CMD_READY_O, .CMD_REQ_I, .WDATA_VALID_I,
    .WDATA_READY_O, .WDATA_I, .RDATA_VALID_O, .RDATA_READY_I, .RDATA_O, .MEM_CMD_VALID_O,
    .MEM_CMD_READY_I, .MEM_CMD_O, .MEM_BANK_O, .MEM_ADDR_O, .MEM_CS_N_O, .MEM_BYTE_MASK_O,
    .MEM_WDATA_O, .MEM_RDATA_VALID_I, .MEM_RDATA_I, .OPEN_BANK_COUNT_O);
  dapp_mem_model i_mem (.clk_i(CLK_I), .rst_n_i(RST_N_I), .stall_i(stall),
    .cmd_valid_i(MEM_CMD_VALID_O), .cmd_ready_o(MEM_CMD_READY_I), .cmd_i(MEM_CMD_O),
    .bank_i(MEM_BANK_O), .addr_i(MEM_ADDR_O), .cs_n_i(MEM_CS_N_O),
    .rdata_valid_o(MEM_RDATA_VALID_I), .rdata_o(MEM_RDATA_I));
  always #2 CLK_I = ~CLK_I;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // random stalls, monitors, timeout
  // --------------------------------------------------------------
  always @(negedge CLK_I) begin
    stall <= hold || $random(seed) % 3 == 0;
    RDATA_READY_I <= $random(seed) % 4 != 0;
  end
  always @(posedge CLK_I) begin
    cyc++;
    if (MEM_CMD_VALID_O && MEM_CMD_READY_I) begin
      n_act += MEM_CMD_O == MC_ACT;
      n_pre += MEM_CMD_O == MC_PRE;
      // the only memory write is an odd byte at column 20h
      if (MEM_CMD_O == MC_WR) begin
        chk(MEM_WDATA_O, wexp);
        chk(MEM_BYTE_MASK_O, 2'h1);
        chk(MEM_ADDR_O, 14'h0020);
      end
    end
    if (RST_N_I && RDATA_VALID_O === 1'b1 && RDATA_READY_I)
      chk(RDATA_O, expq.size() ? expq.pop_front() : 17'h1FFFF);
    if (cyc == 40000) begin
      fail_count++;
      results();
    end
  end
  // --------------------------------------------------------------
  // request driver and expected read pattern
  // --------------------------------------------------------------
  task automatic send(input logic [31:0] a, input logic wr, input logic rs,
                      input logic [15:0] d, input logic ba = 1'b0);
    @(negedge CLK_I);
    CMD_VALID_I = 1;
    CMD_REQ_I = '{a, wr, rs, ba};
    WDATA_VALID_I = wr;
    WDATA_I = d;
    // each path is released on its own accept, so neither is pushed twice
    fork
      begin
        while (!CMD_READY_O) @(negedge CLK_I);
        @(negedge CLK_I);
        CMD_VALID_I = 0;
      end
      begin
        while (wr && !WDATA_READY_O) @(negedge CLK_I);
        @(negedge CLK_I);
        WDATA_VALID_I = 0;
      end
    join
  endtask
  function automatic logic [15:0] ex(input logic [31:0] a);
    int sh;
    logic [13:0] row;
    logic [2:0] bk;
    logic cs;
    sh = 9 + PAGE_SIZE_CODE_I;
    bk = 3'((a >> sh) & ((1 << INTERNAL_BANK_COUNT_I) - 1));
    sh += INTERNAL_BANK_COUNT_I;
    cs = DUAL_CHIP_SELECT_EN_I & a[sh];
    sh += DUAL_CHIP_SELECT_EN_I;
    row = 14'(a >> sh);
    if (DUAL_CHIP_SELECT_EN_I && &INTERNAL_BANK_COUNT_I && &PAGE_SIZE_CODE_I) row[13] = 0;
    ex = {cs, bk, 1'b0, 11'(a[11:1] & ((1 << (8 + PAGE_SIZE_CODE_I)) - 1))} ^ {row, 2'h0};
  endfunction
  task automatic rd(input logic [31:0] a);
    expq.push_back(ex(a));
    send(a, 0, 0, 16'h0);
  endtask
  task automatic drain;
    for (int i = 0; i < 800 && expq.size() > 0; i++) @(posedge CLK_I);
    repeat (4) @(negedge CLK_I);
  endtask
  // --------------------------------------------------------------
  // main sequence: {dual, bank code, page code} per configuration
  // --------------------------------------------------------------
  initial begin
    logic [4:0] cfg [6] = '{5'h00, 5'h05, 5'h0A, 5'h0F, 5'h1F, 5'h19};
    int nb, a0, p0, ps;
    logic [15:0] wd;
    foreach (cfg[c]) begin
      {DUAL_CHIP_SELECT_EN_I, INTERNAL_BANK_COUNT_I, PAGE_SIZE_CODE_I} = cfg[c];
      RST_N_I = 0;
      repeat (3) @(negedge CLK_I);
      RST_N_I = 1;
      ps = 9 + PAGE_SIZE_CODE_I;
      nb = (1 << INTERNAL_BANK_COUNT_I) << DUAL_CHIP_SELECT_EN_I;
      a0 = n_act;
      p0 = n_pre;
      for (int k = 0; k < nb; k++) rd((5 * nb + k) << ps);
      drain();
      chk(OPEN_BANK_COUNT_O, nb);
      chk(n_act - a0, nb);
      chk(n_pre - p0, 0);
      a0 = n_act;
      for (int k = 0; k < nb; k++) rd(((5 * nb + k) << ps) + 2);
      drain();
      chk(n_act - a0, 0);
      a0 = n_act;
      rd((6 * nb) << ps);
      drain();
      chk(n_pre - p0, 1);
      chk(n_act - a0, 1);
      chk(OPEN_BANK_COUNT_O, nb);
      wd = 16'($random(seed));
      wexp = ~wd;
      send(32'h41, 1, 0, ~wd, 1'b1);
      send(32'h0, 1, 1, wd);
      expq.push_back(wd);
      send(32'h0, 0, 1, 16'h0);
      expq.push_back(16'(nb));
      send(32'h2, 0, 1, 16'h0);
      drain();
      chk(expq.size(), 0);
      if (c == 0) begin
        hold = 1;
        // one read waits on the port, one in the sequencer, seven fill the queue
        for (int k = 0; k < 9; k++) rd(k << 1);
        repeat (2) @(negedge CLK_I);
        chk(CMD_READY_O, 0);
        hold = 0;
        drain();
      end
      repeat (12) rd($random(seed) & 32'h0FFF_FFFE);
      drain();
      chk(expq.size(), 0);
    end
    results();
  end
endmodule
`default_nettype wire
